/* src/rfi_ramp_fault_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rfi_params.svh"
module rfi_ramp_fault_regs (
  input  wire logic                  sys_clk,          // 40 MHz system clock
  input  wire logic                  sys_rst,          // Sync reset, high
  input  wire rfi_pkg::rfi_byte_type regAddr,          // Register offset from serial bus
  input  wire rfi_pkg::rfi_byte_type regWdata,         // Write data
  input  wire logic                  regWr,            // Write strobe, one cycle
  input  wire logic                  regRd,            // Read strobe, one cycle
  output rfi_pkg::rfi_byte_type      regRdata,         // Read data, registered
  input  wire logic                  sleepStatus,      // Device reports sleep mode
  input  wire logic                  ledEnable,        // LED on request level
  input  wire logic                  brightUp,         // Pulse: brightness raised
  input  wire logic                  brightDown,       // Pulse: brightness lowered
  input  wire logic                  overcurrentCond,  // Overcurrent level
  input  wire logic                  overvoltageCond,  // Overvoltage level
  input  wire logic                  thermalCond,      // Thermal shutdown level
  input  wire logic                  openDetect,       // Open string level
  input  wire logic                  s1ShortDetect,    // String 1 short level
  input  wire logic                  s2ShortDetect,    // String 2 short level
  input  wire logic                  mfgOvDetect,      // Overvoltage during mfg test
  output logic                       shortTestRun,     // Short test enabled
  output logic                       mfgOvTestRun,     // Overvoltage test enabled
  output logic                       powerRampBusy,    // On/off ramp active
  output logic                       runRampBusy,      // Run ramp active
  output logic                       fault_irq_n       // Interrupt pin, active low
);
  import rfi_pkg::*;

  // Reset images; each field except the flags is cut from its register's image
  localparam rfi_byte_type PowerRst = `RFI_POWER_RAMP_RST;
  localparam rfi_byte_type RunRst   = `RFI_RUN_RAMP_RST;
  localparam rfi_byte_type MaskRst  = `RFI_IRQ_MASK_RST;
  localparam rfi_byte_type TestRst  = `RFI_FAULT_TEST_RST;
  localparam logic [2:0]   FlagRst  = `RFI_IRQ_FLAGS_RST;

  rfi_code_type powerStart_ff;   // Start-up ramp code
  rfi_code_type powerShut_ff;    // Shutdown ramp code
  rfi_code_type runUp_ff;        // Ramp-up code
  rfi_code_type runDown_ff;      // Ramp-down code
  logic [2:0]   irqFlags_ff;     // Latched fault flags
  logic [2:0]   nxt_irqFlags;
  logic [2:0]   srcEn_ff;        // Per-source enables
  logic         globalEn_ff;     // Master enable
  logic         shortEn_ff;
  logic         ovTestEn_ff;
  logic [3:0]   resultSeen_ff;   // Open, string 2, string 1, mfg overvoltage
  logic [3:0]   nxt_resultSeen;
  logic [3:0]   resultDetect;
  logic [3:0]   resultGate;
  logic [3:0]   resultWr;
  logic         ledEnable_ff;
  rfi_byte_type regRdata_ff;
  rfi_byte_type nxt_regRdata;
  logic [2:0]   faultCond;
  logic [2:0]   flagSet;
  logic         flagClr;
  logic         wrPower;
  logic         wrRun;
  logic         wrMask;
  logic         wrTest;

  assign wrPower = regWr && (regAddr == `RFI_POWER_RAMP_OFS);
  assign wrRun   = regWr && (regAddr == `RFI_RUN_RAMP_OFS);
  assign wrMask  = regWr && (regAddr == `RFI_IRQ_MASK_OFS);
  assign wrTest  = regWr && (regAddr == `RFI_FAULT_TEST_OFS);

  // Ramp code registers; bits 7:6 not stored so read zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      powerStart_ff <= PowerRst[`RFI_RAMP_HI_MSB:`RFI_RAMP_HI_LSB];
      powerShut_ff  <= PowerRst[`RFI_RAMP_LO_MSB:`RFI_RAMP_LO_LSB];
      runUp_ff      <= RunRst[`RFI_RAMP_HI_MSB:`RFI_RAMP_HI_LSB];
      runDown_ff    <= RunRst[`RFI_RAMP_LO_MSB:`RFI_RAMP_LO_LSB];
    end else begin
      if (wrPower) begin
        powerStart_ff <= regWdata[`RFI_RAMP_HI_MSB:`RFI_RAMP_HI_LSB];
        powerShut_ff  <= regWdata[`RFI_RAMP_LO_MSB:`RFI_RAMP_LO_LSB];
      end
      if (wrRun) begin
        runUp_ff   <= regWdata[`RFI_RAMP_HI_MSB:`RFI_RAMP_HI_LSB];
        runDown_ff <= regWdata[`RFI_RAMP_LO_MSB:`RFI_RAMP_LO_LSB];
      end
    end
  end

  // Enable register; bits 6:3 have no storage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      globalEn_ff <= MaskRst[`RFI_GLOBAL_BIT];
      srcEn_ff    <= MaskRst[`RFI_OCP_BIT:`RFI_TSD_BIT];
    end else if (wrMask) begin
      globalEn_ff <= regWdata[`RFI_GLOBAL_BIT];
      srcEn_ff    <= regWdata[`RFI_OCP_BIT:`RFI_TSD_BIT];
    end
  end

  // Fault sources gated by both enables
  assign faultCond = {overcurrentCond, overvoltageCond, thermalCond};
  assign flagSet   = faultCond & srcEn_ff & {3{globalEn_ff}};
  // Sleep blocks the clear; hosts mask sources beforehand
  assign flagClr   = regRd && (regAddr == `RFI_IRQ_FLAGS_OFS) && !sleepStatus;

  // Per-source flag; set beats clear so a lingering fault reasserts at once
  for (genvar i = 0; i < 3; i++) begin : g_flag
    assign nxt_irqFlags[i] = (irqFlags_ff[i] & ~flagClr) | flagSet[i];
  end

  // Flag register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqFlags_ff <= FlagRst;
    end else begin
      irqFlags_ff <= nxt_irqFlags;
    end
  end

  // Manufacturing test controls
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shortEn_ff  <= TestRst[`RFI_SHORT_EN_BIT];
      ovTestEn_ff <= TestRst[`RFI_OVP_TEST_EN_BIT];
    end else if (wrTest) begin
      shortEn_ff  <= regWdata[`RFI_SHORT_EN_BIT];
      ovTestEn_ff <= regWdata[`RFI_OVP_TEST_EN_BIT];
    end
  end

  // Sticky results: host may write them, a detection in the same cycle wins
  assign resultDetect = {openDetect, s2ShortDetect, s1ShortDetect, mfgOvDetect};
  assign resultGate   = {{3{shortEn_ff}}, ovTestEn_ff};
  assign resultWr     = {regWdata[`RFI_OPEN_BIT], regWdata[`RFI_S2_SHORT_BIT],
                         regWdata[`RFI_S1_SHORT_BIT], regWdata[`RFI_OVP_SEEN_BIT]};
  for (genvar i = 0; i < 4; i++) begin : g_result
    assign nxt_resultSeen[i] = (wrTest ? resultWr[i] : resultSeen_ff[i]) | (resultGate[i] & resultDetect[i]);
  end

  // Result register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      resultSeen_ff <= {TestRst[`RFI_OPEN_BIT], TestRst[`RFI_S2_SHORT_BIT],
                        TestRst[`RFI_S1_SHORT_BIT], TestRst[`RFI_OVP_SEEN_BIT]};
    end else begin
      resultSeen_ff <= nxt_resultSeen;
    end
  end

  // Read mux, unmapped offsets read zero; last value stands until the next read
  always_comb begin
    nxt_regRdata = regRdata_ff;
    if (regRd) begin
      unique case (regAddr)
        `RFI_POWER_RAMP_OFS: nxt_regRdata = {2'b00, powerStart_ff, powerShut_ff};
        `RFI_RUN_RAMP_OFS:   nxt_regRdata = {2'b00, runUp_ff, runDown_ff};
        `RFI_IRQ_FLAGS_OFS:  nxt_regRdata = {5'h00, irqFlags_ff};
        `RFI_IRQ_MASK_OFS:   nxt_regRdata = {globalEn_ff, 4'h0, srcEn_ff};
        `RFI_FAULT_TEST_OFS: nxt_regRdata = {2'b00, resultSeen_ff[3:1], shortEn_ff,
                                             resultSeen_ff[0], ovTestEn_ff};
        default:             nxt_regRdata = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdata_ff <= 8'h00;
    end else begin
      regRdata_ff <= nxt_regRdata;
    end
  end
  assign regRdata = regRdata_ff;

  // Ramp triggers: level edge of ledEnable, brightness pulses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ledEnable_ff <= 1'b0;
    end else begin
      ledEnable_ff <= ledEnable;
    end
  end

  logic powerEdge, powerOn, runReq, runIsUp;
  assign powerEdge = ledEnable ^ ledEnable_ff;
  assign powerOn   = ledEnable;
  assign runReq    = brightUp | brightDown;
  assign runIsUp   = brightUp;

  // One timer per ramp group; start-up code 0 uses the 4 ms form
  rfi_ramp_timer uPowerTimer (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .startReq (powerEdge),
    .fastLong (powerOn),
    .code     (powerOn ? powerStart_ff : powerShut_ff),
    .busy     (powerRampBusy)
  );

  rfi_ramp_timer uRunTimer (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .startReq (runReq),
    .fastLong (1'b0),
    .code     (runIsUp ? runUp_ff : runDown_ff),
    .busy     (runRampBusy)
  );

  assign shortTestRun = shortEn_ff;
  assign mfgOvTestRun = ovTestEn_ff;
  // Pin low while any flag holds; flags already gated by enables
  assign fault_irq_n  = ~(|irqFlags_ff);
endmodule : rfi_ramp_fault_regs
`default_nettype wire

/* src/rfi_params.svh */
`ifndef RFI_PARAMS_SVH
`define RFI_PARAMS_SVH
// Register offsets
`define RFI_POWER_RAMP_OFS   8'h07
`define RFI_RUN_RAMP_OFS     8'h08
`define RFI_IRQ_FLAGS_OFS    8'h09
`define RFI_IRQ_MASK_OFS     8'h0A
`define RFI_FAULT_TEST_OFS   8'h0B
// Reset values
`define RFI_POWER_RAMP_RST   8'h00
`define RFI_RUN_RAMP_RST     8'h00
`define RFI_IRQ_FLAGS_RST    3'h0
`define RFI_IRQ_MASK_RST     8'h00
`define RFI_FAULT_TEST_RST   8'h00
// Field positions
`define RFI_RAMP_HI_MSB      5
`define RFI_RAMP_HI_LSB      3
`define RFI_RAMP_LO_MSB      2
`define RFI_RAMP_LO_LSB      0
`define RFI_OCP_BIT          2
`define RFI_OVP_BIT          1
`define RFI_TSD_BIT          0
`define RFI_GLOBAL_BIT       7
`define RFI_SHORT_EN_BIT     2
`define RFI_OVP_TEST_EN_BIT  0
`define RFI_OVP_SEEN_BIT     1
`define RFI_S1_SHORT_BIT     3
`define RFI_S2_SHORT_BIT     4
`define RFI_OPEN_BIT         5
// Ramp timing: code 0 start-up 4 ms, fast transition 0.5 ms (in us), code 1 is 261 ms (in us)
`define RFI_CLK_MHZ          40
`define RFI_START_FAST_US    4000
`define RFI_SHORT_FAST_US    500
`define RFI_STEP_BASE_US     261000
`define RFI_START_FAST_CYC   (`RFI_START_FAST_US * `RFI_CLK_MHZ)
`define RFI_SHORT_FAST_CYC   (`RFI_SHORT_FAST_US * `RFI_CLK_MHZ)
`define RFI_STEP_BASE_CYC    (`RFI_STEP_BASE_US * `RFI_CLK_MHZ)
`endif

/* src/rfi_pkg.sv */
package rfi_pkg;
  typedef logic [7:0] rfi_byte_type;
  typedef logic [2:0] rfi_code_type;
  typedef logic [31:0] rfi_cnt_type;
  typedef enum logic [1:0] {
    RFI_IDLE  = 2'b00,
    RFI_UP    = 2'b01,
    RFI_DOWN  = 2'b10
  } rfi_ramp_type;
endpackage : rfi_pkg

/* src/rfi_ramp_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rfi_params.svh"
module rfi_ramp_timer (
  input  wire logic                  sys_clk,   // System clock
  input  wire logic                  sys_rst,   // Sync reset, high
  input  wire logic                  startReq,  // Pulse: begin a ramp
  input  wire logic                  fastLong,  // Code 0 uses the 4 ms form
  input  wire rfi_pkg::rfi_code_type code,      // Ramp duration code
  output logic                       busy       // Ramp in progress
);
  import rfi_pkg::*;

  rfi_cnt_type cnt_ff;
  rfi_cnt_type loadVal;

  // Code 0 is fast; others double from the 261 ms base
  always_comb begin
    if (code == 3'h0) begin
      loadVal = fastLong ? 32'(`RFI_START_FAST_CYC) : 32'(`RFI_SHORT_FAST_CYC);
    end else begin
      loadVal = 32'(`RFI_STEP_BASE_CYC) << (code - 3'h1);
    end
  end

  // Down counter; a new request restarts the ramp
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_ff <= 32'h0;
    end else if (startReq) begin
      cnt_ff <= loadVal;
    end else if (cnt_ff != 32'h0) begin
      cnt_ff <= cnt_ff - 32'h1;
    end
  end

  assign busy = (cnt_ff != 32'h0);
endmodule : rfi_ramp_timer
`default_nettype wire

/* verif/rfi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rfi_host (
  input  wire logic                  sys_clk,  // System clock
  input  wire rfi_pkg::rfi_byte_type regRdata, // Read data
  output rfi_pkg::rfi_byte_type      regAddr,  // Register offset
  output rfi_pkg::rfi_byte_type      regWdata, // Write data
  output logic                       regWr,    // Write strobe
  output logic                       regRd     // Read strobe
);
  import rfi_pkg::*;
  // Bus idle until the first request
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // One byte written; strobe lasts exactly one taking edge
  task automatic wr(input rfi_byte_type a, input rfi_byte_type d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  // Data is registered at the taking edge, so look just after it
  task automatic rd(input rfi_byte_type a, output rfi_byte_type d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
endmodule : rfi_host
`default_nettype wire

/* verif/rfi_ramp_fault_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module rfi_ramp_fault_regs_chk (
  input wire logic sys_clk, sys_rst, regWr, regRd, sleepStatus, ledEnable, brightUp, // Clock, reset, controls
  input wire logic overcurrentCond, overvoltageCond, thermalCond,                    // Fault levels
  input wire logic shortTestRun, mfgOvTestRun, powerRampBusy, runRampBusy, fault_irq_n, // Outputs
  input wire rfi_pkg::rfi_byte_type regAddr, regWdata, regRdata                     // Register bus
);
  import rfi_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic anyCond;
  // Any fault level, mask not tracked here
  assign anyCond = overcurrentCond | overvoltageCond | thermalCond;
  ctrl_write_a: assert property (regWr && regAddr == 8'h0B |=>
    shortTestRun == $past(regWdata[2]) && mfgOvTestRun == $past(regWdata[0])) else $error("test enable mismatch");
  ramp_rsvd_a: assert property (regRd && (regAddr == 8'h07 || regAddr == 8'h08) |=> regRdata[7:6] == 2'h0)
    else $error("ramp reserved bits set");
  flag_rsvd_a: assert property (regRd && regAddr == 8'h09 |=> regRdata[7:3] == 5'h00)
    else $error("flag reserved bits set");
  mask_rsvd_a: assert property (regRd && regAddr == 8'h0A |=> regRdata[6:3] == 4'h0)
    else $error("mask reserved bits set");
  irq_cause_a: assert property ($fell(fault_irq_n) |-> $past(anyCond) || $past(anyCond, 2))
    else $error("interrupt without fault");
  irq_release_a: assert property (!anyCond ##1 (regRd && regAddr == 8'h09 && !sleepStatus && !anyCond)
    ##1 !anyCond |=> fault_irq_n) else $error("interrupt kept after clearing read");
  sleep_keep_a: assert property (regRd && regAddr == 8'h09 && sleepStatus && !fault_irq_n |=> !fault_irq_n [*2])
    else $error("sleep read released interrupt");
  irq_hold_a: assert property (!fault_irq_n && !regRd |=> !fault_irq_n)
    else $error("interrupt dropped without read");
  power_start_a: assert property ($changed(ledEnable) |-> ##[1:3] powerRampBusy)
    else $error("on/off ramp did not start");
  run_start_a: assert property (brightUp |-> ##[1:3] runRampBusy)
    else $error("run ramp did not start");
  // Main scenarios reached
  cover property (regRd && regAddr == 8'h09 && !fault_irq_n);
  cover property (regRd && sleepStatus);
  cover property ($fell(runRampBusy));
endmodule : rfi_ramp_fault_regs_chk
bind rfi_ramp_fault_regs rfi_ramp_fault_regs_chk chk (.*);
`default_nettype wire

/* verif/rfi_ramp_fault_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module rfi_ramp_fault_regs_bench;
  import rfi_pkg::*;
  typedef struct { rfi_byte_type a, w, e; } rfi_row_type;
  logic sys_clk = 1'b0, sys_rst = 1'b1, sleepStatus = 1'b0, ledEnable = 1'b0, brightUp = 1'b0, brightDown = 1'b0;
  logic [2:0] cond = 3'h0; // Overcurrent, overvoltage, thermal
  logic [3:0] det = 4'h0;  // Open, string 2, string 1, mfg overvoltage
  logic regWr, regRd, shortTestRun, mfgOvTestRun, powerRampBusy, runRampBusy, fault_irq_n;
  rfi_byte_type regAddr, regWdata, regRdata, rdv;
  int errors = 0, compares = 0, cycles = 0, n, m, k;
  // Write value, then expected read-back; last rows hit read-only and unmapped places
  rfi_row_type rows [7] = '{'{8'h07, 8'hFF, 8'h3F}, '{8'h08, 8'hFF, 8'h3F}, '{8'h0A, 8'hFF, 8'h87},
    '{8'h0B, 8'hFF, 8'h3F}, '{8'h0B, 8'h00, 8'h00}, '{8'h09, 8'hFF, 8'h00}, '{8'h0C, 8'hFF, 8'h00}};
  rfi_byte_type gates [2] = '{8'h07, 8'h80};
  logic [3:0] pats [2] = '{4'hA, 4'h5};
  rfi_ramp_fault_regs DUT (.*, .overcurrentCond(cond[2]), .overvoltageCond(cond[1]), .thermalCond(cond[0]),
    .openDetect(det[3]), .s2ShortDetect(det[2]), .s1ShortDetect(det[1]), .mfgOvDetect(det[0]));
  rfi_host host (.*);
  always #12.5 sys_clk = ~sys_clk;
  // Whole run needs about 40k cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Fault levels held two cycles, then settle
  task automatic pulse(input logic [2:0] c);
    @(posedge sys_clk);
    cond <= c;
    repeat (2) @(posedge sys_clk);
    cond <= 3'h0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : pulse
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (n = 7; n < 12; n++) begin
      host.rd(8'(n), rdv);
      `CHK(rdv, 8'h00)
    end
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      host.rd(rows[i].a, rdv);
      `CHK(rdv, rows[i].e)
    end
    // Each source alone, master on
    for (n = 0; n < 3; n++) begin
      pulse(3'(1 << n));
      `CHK(fault_irq_n, 1'b0)
      host.rd(8'h09, rdv);
      `CHK(rdv, 8'(1 << n))
      @(posedge sys_clk);
      #1;
      `CHK(fault_irq_n, 1'b1)
    end
    // Fault still present across clearing reads
    @(posedge sys_clk);
    cond <= 3'h2;
    repeat (2) begin
      host.rd(8'h09, rdv);
      `CHK(rdv, 8'h02)
    end
    @(posedge sys_clk);
    cond <= 3'h0;
    host.rd(8'h09, rdv);
    host.rd(8'h09, rdv);
    `CHK(rdv, 8'h00)
    // Master or source enable missing blocks the flag
    foreach (gates[i]) begin
      host.wr(8'h0A, gates[i]);
      pulse(3'h7);
      `CHK(fault_irq_n, 1'b1)
      host.rd(8'h09, rdv);
      `CHK(rdv, 8'h00)
    end
    // Flags survive reads while sleeping
    host.wr(8'h0A, 8'h87);
    pulse(3'h1);
    host.wr(8'h0A, 8'h00);
    @(posedge sys_clk);
    sleepStatus <= 1'b1;
    repeat (2) begin
      host.rd(8'h09, rdv);
      `CHK(rdv, 8'h01)
    end
    @(posedge sys_clk);
    sleepStatus <= 1'b0;
    host.rd(8'h09, rdv);
    host.rd(8'h09, rdv);
    `CHK(rdv, 8'h00)
    // Test results land in their own bits only while enabled
    foreach (pats[i]) begin
      host.wr(8'h0B, 8'h05);
      @(posedge sys_clk);
      det <= pats[i];
      @(posedge sys_clk);
      det <= 4'h0;
      host.rd(8'h0B, rdv);
      `CHK(rdv, {2'b00, pats[i][3:1], 1'b1, pats[i][0], 1'b1})
      `CHK({shortTestRun, mfgOvTestRun}, 2'b11)
    end
    host.wr(8'h0B, 8'h00);
    @(posedge sys_clk);
    det <= 4'hF;
    host.rd(8'h0B, rdv);
    `CHK(rdv, 8'h00)
    // Mid-run reset drops flags, enables, test controls and results
    host.wr(8'h0A, 8'h87);
    host.wr(8'h0B, 8'h05);
    pulse(3'h4);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({fault_irq_n, shortTestRun, mfgOvTestRun}, 3'b100)
    host.rd(8'h0A, rdv);
    `CHK(rdv, 8'h00)
    host.rd(8'h0B, rdv);
    `CHK(rdv, 8'h00)
    // Ramps: turn-on starts; run code 0 and shutdown code 0 timed together
    @(posedge sys_clk);
    ledEnable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK(powerRampBusy, 1'b1)
    host.wr(8'h08, 8'h00);
    @(posedge sys_clk);
    brightDown <= 1'b1;
    ledEnable <= 1'b0;
    @(posedge sys_clk);
    brightDown <= 1'b0;
    k = 0;
    n = 0;
    m = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
      if (runRampBusy === 1'b1) n = k;
      if (powerRampBusy === 1'b1) m = k;
    end while ((runRampBusy !== 1'b0 || powerRampBusy !== 1'b0) && k < 30000);
    `CHK((n > 19996 && n < 20002), 1'b1)
    `CHK((m > 19996 && m < 20002), 1'b1)
    host.wr(8'h08, 8'h08);
    @(posedge sys_clk);
    brightUp <= 1'b1;
    @(posedge sys_clk);
    brightUp <= 1'b0;
    repeat (20100) @(posedge sys_clk);
    #1;
    `CHK(runRampBusy, 1'b1)
    print_verdict();
  end
endmodule : rfi_ramp_fault_regs_bench
`default_nettype wire
